// ==== core/pcs_pkg.sv ====
/*
 * Shared constants and types for the power-up clock strap capture block.
 * Assumes a single 125 MHz system clock; all board pins arrive asynchronously.
 */
`default_nettype none

package pcs_pkg;

   // System clock rate, kept for anyone deriving timing counts
   localparam int SYS_CLK_MHZ = 125;

   // Strap bus layout
   localparam int STRAP_W = 6;
   localparam int STRAP_FRAME_MODE_BIT = 5;
   localparam int STRAP_FWD_SEL_BIT = 4;
   localparam int STRAP_DIV_MSB = 3;
   localparam int STRAP_DIV_LSB = 0;
   localparam int DIV_CODE_W = 4;
   localparam int DIVISOR_W = 5;

   // Divisor code points
   localparam logic [DIV_CODE_W-1:0] DIV_CODE_EIGHT = 4'h0;
   localparam logic [DIV_CODE_W-1:0] DIV_CODE_LOW_MIN = 4'h3;
   localparam logic [DIV_CODE_W-1:0] DIV_CODE_HIGH_MIN = 4'h8;
   localparam logic [DIVISOR_W-1:0] DIVISOR_EIGHT = 5'h08;

   // Configuration reset values
   localparam logic [DIV_CODE_W-1:0] RST_DIV_CODE = 4'h0;
   localparam logic RST_FRAME_COPY = 1'b0;
   localparam logic RST_FWD_SEL = 1'b0;

   // Bypass select encoding: low routes the reference clock onto the global clock
   localparam logic BYPASS_SEL_REFERENCE = 1'b0;

   // Frame clock and forwarded-reset sampling selections
   localparam logic FRAME_MODE_SAMPLE_EXT = 1'b0;
   localparam logic FWD_SEL_EXTERNAL = 1'b0;

   // Reset sequencer states
   typedef enum logic [1:0] {
      PCS_SETTLE_WAIT = 2'b00,
      PCS_CAPTURE = 2'b01,
      PCS_CONFIGURED = 2'b10
   } pcs_state_t;

   // Decode a strap divisor code into a divide ratio; unused codes fall back to eight
   function automatic logic [DIVISOR_W-1:0] pcs_decode_divisor(
      input logic [DIV_CODE_W-1:0] code);
      logic [DIVISOR_W-1:0] ratio;
      ratio = DIVISOR_EIGHT;
      if (code >= DIV_CODE_HIGH_MIN) begin
         ratio = {1'b0, code} + 5'h01;
      end else if (code >= DIV_CODE_LOW_MIN) begin
         ratio = {1'b0, code};
      end
      return ratio;
   endfunction

endpackage : pcs_pkg

`default_nettype wire

// ==== core/pcs_clk_if.sv ====
/*
 * Carrier between the strap core and its output clock divider.
 * Assumes both ends run on sys_clk; tick is a one-cycle global clock event.
 */
`default_nettype none

interface pcs_clk_if;
   import pcs_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;

   logic tick;
   logic [DIVISOR_W-1:0] divisor;
   logic div_clk;
   logic div_rise;

   modport ctrl (output tick, output divisor, input div_clk, input div_rise);
   modport div (input tick, input divisor, output div_clk, output div_rise);
endinterface : pcs_clk_if

`default_nettype wire

// ==== core/pcs_clock_divider.sv ====
/*
 * Divides global clock events down to the divided output clock.
 * Assumes tick is one cycle wide and divisor is at least three.
 */
`default_nettype none

module pcs_clock_divider
   import pcs_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_b,
   // Divider carrier
   pcs_clk_if.div link
);
   timeunit 1ns;
   timeprecision 1ps;

   typedef struct packed {
      logic [DIVISOR_W-1:0] cnt;
      logic div_clk;
      logic div_rise;
   } pcs_div_reg_t;

   pcs_div_reg_t r;
   pcs_div_reg_t next_r;
   logic wrap;

   assign wrap = (r.cnt >= link.divisor - 5'h01);

   // Count global events; output high for the first divisor/2 events (rounded down) of each period [RULE_06] [RULE_10]
   always_comb begin
      next_r = r;
      next_r.div_rise = 1'b0;
      if (link.tick) begin
         next_r.cnt = wrap ? '0 : r.cnt + 5'h01;
         next_r.div_rise = wrap;
         next_r.div_clk = (next_r.cnt < (link.divisor >> 1));
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign link.div_clk = r.div_clk;
   assign link.div_rise = r.div_rise;

   a_div_wrap: assert property (@(posedge sys_clk) disable iff (!rst_b) // [RULE_10]
      (link.tick && r.cnt == link.divisor - 5'h01) |=> (r.cnt == '0 && r.div_rise))
      else $error("divider did not wrap at the divisor");

   a_div_no_tick: assert property (@(posedge sys_clk) disable iff (!rst_b) // [RULE_06]
      !link.tick |=> ($stable(r.cnt) && !r.div_rise))
      else $error("divider advanced without a global clock event");

endmodule // pcs_clock_divider

`default_nettype wire

// ==== core/pcs_strap_core.sv ====
/*
 * Power-up strap capture and clock setup: latches divisor and frame options
 * on the rise of power-good, selects the global clock source and derives the
 * internal frame clock and forwarded-clock reset.
 * Assumes every board pin is asynchronous and that clock pins are slow enough
 * against sys_clk to be sampled as levels.
 */
`default_nettype none

// Functional notes
// RULE_01: On power-good rise, latch straps including divisor and enable the charge pump.
// RULE_02: Straps are sampled only at the power-good rising edge.
// RULE_03: After setup, strap pins pass through as interrupt requests.
// RULE_04: During sampling the core stays in reset with no system activity.
// RULE_05: Bypass select is watched always; 0 picks reference, 1 picks PLL.
// RULE_06: The divided output clock keeps running in bypass mode.
// RULE_07: The board may feed the divided clock back through an external PLL.
// RULE_08: Strap bit 5 picks sampled external frame clock or divided clock copy.
// RULE_09: Strap bit 4 picks which frame clock samples the forwarded reset.
// RULE_10: Strap bits 3:0 set the divisor: 3-7, 0 gives 8, 9-16.
// RULE_11: PLL mode aligns divided clock to reference; bypass runs it slower.
// RULE_12: Power-good low holds the sequencer initial and the oscillator nominal.
// RULE_13: The board never steps the reference frequency by more than 333 MHz.
// RULE_14: Before power-good the sequencer waits in its settle state.
// RULE_15: Captured configuration holds until power-good falls again.

module pcs_strap_core
   import pcs_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_b,
   // Board pins
   input wire logic power_good_in,
   input wire logic pll_bypass_select,
   input wire logic reference_clock_in,
   input wire logic pll_clock_in,
   input wire logic [STRAP_W-1:0] strap_irq_in,
   input wire logic frame_clock_in,
   input wire logic forwarded_clock_reset_in,
   // Clock control
   output logic global_clock_from_pll,
   output logic divided_clock_out,
   output logic pll_charge_pump_enable,
   output logic pll_nominal_speed,
   output logic pll_phase_align_enable,
   // Sequencer
   output logic [1:0] seq_state,
   output logic core_reset_b,
   output logic system_activity_enable,
   // Captured configuration
   output logic cfg_frame_copy_mode,
   output logic cfg_fwd_reset_internal_sel,
   output logic [DIV_CODE_W-1:0] cfg_divisor_code,
   output logic [DIVISOR_W-1:0] cfg_divisor,
   // Run-time signals
   output logic [STRAP_W-1:0] irq_request,
   output logic internal_frame_clock,
   output logic internal_fwd_reset
);
   timeunit 1ns;
   timeprecision 1ps;

   typedef struct packed {
      logic pg_s1;
      logic pg_s2;
      logic pg_d;
      logic byp_s1;
      logic byp_s2;
      logic ref_s1;
      logic ref_s2;
      logic ref_d;
      logic pll_s1;
      logic pll_s2;
      logic pll_d;
      logic frm_s1;
      logic frm_s2;
      logic frm_d;
      logic fwd_s1;
      logic fwd_s2;
      logic [STRAP_W-1:0] irq_s1;
      logic [STRAP_W-1:0] irq_s2;
      pcs_state_t state;
      logic frame_copy;
      logic fwd_sel;
      logic [DIV_CODE_W-1:0] div_code;
      logic pump;
      logic from_pll;
      logic [STRAP_W-1:0] irq_out;
      logic frame_int;
      logic fwd_rst;
   } pcs_core_reg_t;

   pcs_core_reg_t r;
   pcs_core_reg_t next_r;
   logic pg_rise;
   logic ext_frame_rise;
   logic frame_sample;

   pcs_clk_if clk_link ();

   // Edge detects read only second-stage or later flops
   assign pg_rise = r.pg_s2 & ~r.pg_d;
   assign ext_frame_rise = r.frm_s2 & ~r.frm_d;

   // Global clock event from whichever source drives it [RULE_05]
   assign clk_link.tick = r.from_pll ? (r.pll_s2 & ~r.pll_d) : (r.ref_s2 & ~r.ref_d);
   assign clk_link.divisor = pcs_decode_divisor(r.div_code); // [RULE_10]

   // Forwarded reset is sampled on the selected frame clock's rising edge [RULE_09]
   assign frame_sample = (r.fwd_sel == FWD_SEL_EXTERNAL) ? ext_frame_rise : clk_link.div_rise;

   always_comb begin
      next_r = r;
      // Two-flop synchronisers for every board pin
      next_r.pg_s1 = power_good_in;
      next_r.pg_s2 = r.pg_s1;
      next_r.pg_d = r.pg_s2;
      next_r.byp_s1 = pll_bypass_select;
      next_r.byp_s2 = r.byp_s1;
      next_r.ref_s1 = reference_clock_in;
      next_r.ref_s2 = r.ref_s1;
      next_r.ref_d = r.ref_s2;
      next_r.pll_s1 = pll_clock_in;
      next_r.pll_s2 = r.pll_s1;
      next_r.pll_d = r.pll_s2;
      next_r.frm_s1 = frame_clock_in;
      next_r.frm_s2 = r.frm_s1;
      next_r.frm_d = r.frm_s2;
      next_r.fwd_s1 = forwarded_clock_reset_in;
      next_r.fwd_s2 = r.fwd_s1;
      next_r.irq_s1 = strap_irq_in;
      next_r.irq_s2 = r.irq_s1;

      // Bypass select is followed at all times, not only at power-up [RULE_05]
      next_r.from_pll = (r.byp_s2 != BYPASS_SEL_REFERENCE);

      // Reset sequencer; power-good low overrides every state [RULE_12] [RULE_14]
      case (r.state)
         PCS_SETTLE_WAIT: begin
            if (pg_rise) begin
               // The only place configuration is loaded [RULE_01] [RULE_02]
               next_r.frame_copy = r.irq_s2[STRAP_FRAME_MODE_BIT];
               next_r.fwd_sel = r.irq_s2[STRAP_FWD_SEL_BIT];
               next_r.div_code = r.irq_s2[STRAP_DIV_MSB:STRAP_DIV_LSB];
               next_r.pump = 1'b1;
               next_r.state = PCS_CAPTURE;
            end
         end
         PCS_CAPTURE: begin
            next_r.state = PCS_CONFIGURED;
         end
         PCS_CONFIGURED: begin
            // Configuration fields are left untouched here [RULE_15]
            next_r.state = PCS_CONFIGURED;
         end
         default: begin
            next_r.state = PCS_SETTLE_WAIT;
         end
      endcase
      if (!r.pg_s2) begin
         next_r.state = PCS_SETTLE_WAIT;
         next_r.pump = 1'b0;
      end

      // Straps become interrupt lines only once set up; quiet while sampling [RULE_03] [RULE_04]
      next_r.irq_out = (r.state == PCS_CONFIGURED) ? r.irq_s2 : '0;

      // Internal frame clock: copy of divided clock or sampled external clock [RULE_08]
      next_r.frame_int = (r.frame_copy != FRAME_MODE_SAMPLE_EXT) ? clk_link.div_clk : r.frm_s2;

      if (frame_sample) begin
         next_r.fwd_rst = r.fwd_s2; // [RULE_09]
      end
   end

   // Single state register; configuration resets to its defaults
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         r <= '0;
         r.state <= PCS_SETTLE_WAIT;
         r.frame_copy <= RST_FRAME_COPY;
         r.fwd_sel <= RST_FWD_SEL;
         r.div_code <= RST_DIV_CODE;
      end else begin
         r <= next_r;
      end
   end

   pcs_clock_divider u_divider (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .link(clk_link.div)
   );

   // Output drive; the core stays in reset until configuration has settled [RULE_04]
   assign global_clock_from_pll = r.from_pll;
   assign divided_clock_out = clk_link.div_clk; // [RULE_06]
   assign pll_charge_pump_enable = r.pump;
   assign pll_nominal_speed = (r.state == PCS_SETTLE_WAIT); // [RULE_12]
   // Phase alignment only makes sense with the PLL actually driving the global clock
   assign pll_phase_align_enable = r.pump & r.from_pll & (r.state == PCS_CONFIGURED); // [RULE_11]
   assign seq_state = r.state;
   assign core_reset_b = (r.state == PCS_CONFIGURED);
   assign system_activity_enable = (r.state == PCS_CONFIGURED);
   assign cfg_frame_copy_mode = r.frame_copy;
   assign cfg_fwd_reset_internal_sel = r.fwd_sel;
   assign cfg_divisor_code = r.div_code;
   assign cfg_divisor = clk_link.divisor;
   assign irq_request = r.irq_out;
   assign internal_frame_clock = r.frame_int;
   assign internal_fwd_reset = r.fwd_rst;

   a_strap_capture: assert property (@(posedge sys_clk) disable iff (!rst_b) // [RULE_02]
      pg_rise |=> (r.frame_copy == $past(r.irq_s2[STRAP_FRAME_MODE_BIT])
                   && r.fwd_sel == $past(r.irq_s2[STRAP_FWD_SEL_BIT])
                   && r.div_code == $past(r.irq_s2[STRAP_DIV_MSB:STRAP_DIV_LSB])))
      else $error("straps not captured on power-good rise");

   a_pump_enable: assert property (@(posedge sys_clk) disable iff (!rst_b) // [RULE_01]
      pg_rise |=> (pll_charge_pump_enable && seq_state == PCS_CAPTURE)
                  ##1 (!$past(r.pg_s2) || seq_state == PCS_CONFIGURED))
      else $error("charge pump or sequencer wrong after power-good rise");

   a_cfg_stable: assert property (@(posedge sys_clk) disable iff (!rst_b) // [RULE_15]
      !pg_rise |=> ($stable(r.frame_copy) && $stable(r.fwd_sel) && $stable(r.div_code)))
      else $error("configuration changed outside power-good rise");

   a_quiet_sampling: assert property (@(posedge sys_clk) disable iff (!rst_b) // [RULE_04]
      (seq_state != PCS_CONFIGURED) |-> (!core_reset_b && !system_activity_enable)
         ##1 (irq_request == '0))
      else $error("activity while configuration is being sampled");

   a_irq_pass: assert property (@(posedge sys_clk) disable iff (!rst_b) // [RULE_03]
      (seq_state == PCS_CONFIGURED) |=> (irq_request == $past(r.irq_s2)))
      else $error("interrupt request does not follow strap pins");

   a_bypass_follow: assert property (@(posedge sys_clk) disable iff (!rst_b) // [RULE_05]
      ##1 (global_clock_from_pll == $past(r.byp_s2)))
      else $error("global clock source does not follow bypass select");

   a_pg_low_settle: assert property (@(posedge sys_clk) disable iff (!rst_b) // [RULE_12]
      !r.pg_s2 |=> (seq_state == PCS_SETTLE_WAIT && pll_nominal_speed
                    && !pll_charge_pump_enable))
      else $error("sequencer left settle state with power-good low");

   a_fwd_sample: assert property (@(posedge sys_clk) disable iff (!rst_b) // [RULE_09]
      (frame_sample |=> internal_fwd_reset == $past(r.fwd_s2))
      and (!frame_sample |=> $stable(internal_fwd_reset)))
      else $error("forwarded reset not sampled on selected frame edge");

   a_frame_copy: assert property (@(posedge sys_clk) disable iff (!rst_b) // [RULE_08]
      (r.frame_copy |=> internal_frame_clock == $past(clk_link.div_clk))
      and (!r.frame_copy |=> internal_frame_clock == $past(r.frm_s2)))
      else $error("internal frame clock from wrong source");

endmodule // pcs_strap_core

`default_nettype wire

// ==== tb/pcs_board_model.sv ====
/*
 * Board-side clock sources for the strap core: reference, PLL oscillator
 * and external frame clock, each a fixed whole number of sys_clk cycles.
 * Assumes the bench drives power-good, straps and bypass itself.
 */
`default_nettype none

module pcs_board_model
   import pcs_pkg::*;
#(
   parameter int REF_HALF = 4,
   parameter int PLL_HALF = 3,
   parameter int FRAME_HALF = 5
)(
   // Clock
   input wire logic sys_clk,
   // Board clock pins
   output logic reference_clock_in,
   output logic pll_clock_in,
   output logic frame_clock_in
);
   timeunit 1ns;
   timeprecision 1ps;

   int ref_cnt = 0;
   int pll_cnt = 0;
   int frm_cnt = 0;

   initial begin
      reference_clock_in = 1'b0;
      pll_clock_in = 1'b0;
      frame_clock_in = 1'b0;
   end

   // Rates never change, so no frequency step can occur
   // Reference runs free so the core may lock a feedback loop on it
   always @(posedge sys_clk) begin
      ref_cnt <= (ref_cnt == REF_HALF - 1) ? 0 : ref_cnt + 1;
      pll_cnt <= (pll_cnt == PLL_HALF - 1) ? 0 : pll_cnt + 1;
      frm_cnt <= (frm_cnt == FRAME_HALF - 1) ? 0 : frm_cnt + 1;
      if (ref_cnt == REF_HALF - 1) reference_clock_in <= ~reference_clock_in;
      if (pll_cnt == PLL_HALF - 1) pll_clock_in <= ~pll_clock_in;
      if (frm_cnt == FRAME_HALF - 1) frame_clock_in <= ~frame_clock_in;
   end
endmodule // pcs_board_model

`default_nettype wire

// ==== tb/pcs_strap_core_tb.sv ====
/*
 * Self-checking bench for the strap core: capture of every divisor code,
 * interrupt pass-through, bypass, divided and frame clock periods.
 * Assumes the board model clocks have periods of 8, 6 and 10 cycles.
 */
`default_nettype none

module pcs_strap_core_tb
   import pcs_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic sys_clk = 1'b0;
   logic rst_b = 1'b0;
   logic power_good_in = 1'b0;
   logic pll_bypass_select = 1'b0;
   logic [STRAP_W-1:0] strap_irq_in = 6'h00;
   logic forwarded_clock_reset_in = 1'b0;
   logic reference_clock_in, pll_clock_in, frame_clock_in;
   logic global_clock_from_pll, divided_clock_out, pll_charge_pump_enable;
   logic pll_nominal_speed, pll_phase_align_enable, core_reset_b;
   logic system_activity_enable, cfg_frame_copy_mode, cfg_fwd_reset_internal_sel;
   logic [1:0] seq_state;
   logic [DIV_CODE_W-1:0] cfg_divisor_code;
   logic [DIVISOR_W-1:0] cfg_divisor;
   logic [STRAP_W-1:0] irq_request;
   logic internal_frame_clock, internal_fwd_reset;
   int n_fail = 0;
   int total_checks = 0;

   // 125 MHz system clock
   initial begin
      forever #4 sys_clk = ~sys_clk;
   end

   pcs_board_model board_u (.sys_clk(sys_clk), .reference_clock_in(reference_clock_in),
      .pll_clock_in(pll_clock_in), .frame_clock_in(frame_clock_in));

   pcs_strap_core dut_u (.sys_clk(sys_clk), .rst_b(rst_b), .power_good_in(power_good_in),
      .pll_bypass_select(pll_bypass_select), .reference_clock_in(reference_clock_in),
      .pll_clock_in(pll_clock_in), .strap_irq_in(strap_irq_in),
      .frame_clock_in(frame_clock_in), .forwarded_clock_reset_in(forwarded_clock_reset_in),
      .global_clock_from_pll(global_clock_from_pll), .divided_clock_out(divided_clock_out),
      .pll_charge_pump_enable(pll_charge_pump_enable), .pll_nominal_speed(pll_nominal_speed),
      .pll_phase_align_enable(pll_phase_align_enable), .seq_state(seq_state),
      .core_reset_b(core_reset_b), .system_activity_enable(system_activity_enable),
      .cfg_frame_copy_mode(cfg_frame_copy_mode),
      .cfg_fwd_reset_internal_sel(cfg_fwd_reset_internal_sel),
      .cfg_divisor_code(cfg_divisor_code), .cfg_divisor(cfg_divisor),
      .irq_request(irq_request), .internal_frame_clock(internal_frame_clock),
      .internal_fwd_reset(internal_fwd_reset));

   task automatic results();
      $display("Checks %0d, mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Sample n edges later, once the last edge's updates have landed
   task automatic step(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask

   // Bounded wait on a selected output; a lapse ends the run
   task automatic wait_for(input int sel, input logic [1:0] val, input int bound);
      logic [1:0] seen;
      for (int i = 0; i < bound; i++) begin
         step(1);
         seen = (sel == 0) ? seq_state : (sel == 1) ? {1'b0, internal_fwd_reset} :
            (sel == 2) ? {1'b0, divided_clock_out} : {1'b0, internal_frame_clock};
         if (seen === val) return;
      end
      n_fail++;
      $display("Error wait sel %0d expected %h seen %h", sel, val, seen);
      results();
   endtask

   // Cycles between two rises of the divided (sel 2) or frame (sel 3) clock
   task automatic period(input int sel, input int exp);
      int cnt;
      logic v;
      logic low_seen;
      wait_for(sel, 2'b00, 600);
      wait_for(sel, 2'b01, 600);
      cnt = 0;
      low_seen = 1'b0;
      v = 1'b0;
      // Count from one rise through the low phase to the next rise, so both phases count
      for (int i = 0; i < 600; i++) begin
         step(1);
         cnt++;
         v = (sel == 2) ? divided_clock_out : internal_frame_clock;
         if (v === 1'b0) low_seen = 1'b1;
         if (low_seen && v === 1'b1) break;
      end
      if (low_seen && v === 1'b1) begin
         check($sformatf("clock period sel %0d", sel), exp[7:0], cnt[7:0]);
      end else begin
         n_fail++;
         $display("Error clock period sel %0d expected %0d seen no rise", sel, exp);
         results();
      end
   endtask

   // Reset and settle-wait values, pins ignored before power-good
   task automatic reset_values();
      strap_irq_in <= 6'h3f;
      step(1);
      check("seq_state", {6'h00, PCS_SETTLE_WAIT}, {6'h00, seq_state});
      check("nominal speed", 8'h01, {7'h00, pll_nominal_speed});
      check("core reset", 8'h00, {7'h00, core_reset_b});
      check("irq before setup", 8'h00, {2'h0, irq_request});
      check("pump before pg", 8'h00, {7'h00, pll_charge_pump_enable});
   endtask

   // One full power-good cycle with the given straps
   task automatic capture(input logic [STRAP_W-1:0] s);
      logic [4:0] d;
      logic [3:0] c;
      c = s[3:0];
      d = (c >= 4'h8) ? {1'b0, c} + 5'h01 : (c >= 4'h3) ? {1'b0, c} : 5'h08;
      @(posedge sys_clk);
      strap_irq_in <= s;
      power_good_in <= 1'b1;
      wait_for(0, PCS_CAPTURE, 10);
      check("reset in capture", 8'h00, {7'h00, core_reset_b});
      check("activity in capture", 8'h00, {7'h00, system_activity_enable});
      check("pump", 8'h01, {7'h00, pll_charge_pump_enable});
      check("nominal off", 8'h00, {7'h00, pll_nominal_speed});
      check("divisor", {3'h0, d}, {3'h0, cfg_divisor});
      check("divisor code", {4'h0, c}, {4'h0, cfg_divisor_code});
      check("frame mode", {7'h00, s[5]}, {7'h00, cfg_frame_copy_mode});
      check("fwd sel", {7'h00, s[4]}, {7'h00, cfg_fwd_reset_internal_sel});
      wait_for(0, PCS_CONFIGURED, 4);
      check("core released", 8'h01, {7'h00, core_reset_b});
      check("activity on", 8'h01, {7'h00, system_activity_enable});
      // Straps now act as interrupts and must leave the setup alone
      strap_irq_in <= ~s;
      step(5);
      check("irq pass", {2'h0, ~s}, {2'h0, irq_request});
      check("cfg kept", {4'h0, c}, {4'h0, cfg_divisor_code});
      check("frame kept", {7'h00, s[5]}, {7'h00, cfg_frame_copy_mode});
      // Bypass low picks the reference, high the PLL
      period(2, d * 8);
      period(3, s[5] ? d * 8 : 10);
      pll_bypass_select <= 1'b1;
      step(4);
      check("from pll", 8'h01, {7'h00, global_clock_from_pll});
      check("phase align", 8'h01, {7'h00, pll_phase_align_enable});
      period(2, d * 6);
      pll_bypass_select <= 1'b0;
      step(4);
      check("from reference", 8'h00, {7'h00, global_clock_from_pll});
      check("no phase align", 8'h00, {7'h00, pll_phase_align_enable});
      forwarded_clock_reset_in <= 1'b1;
      wait_for(1, 2'b01, 600);
      forwarded_clock_reset_in <= 1'b0;
      wait_for(1, 2'b00, 600);
      power_good_in <= 1'b0;
      wait_for(0, PCS_SETTLE_WAIT, 10);
      step(1);
      check("nominal again", 8'h01, {7'h00, pll_nominal_speed});
      check("irq masked", 8'h00, {2'h0, irq_request});
      step(3);
      check("pump off", 8'h00, {7'h00, pll_charge_pump_enable});
   endtask

   // Main sequence: reset, then every divisor code with rotating mode bits
   initial begin
      step(5);
      reset_values();
      rst_b <= 1'b1;
      step(8);
      reset_values();
      for (int k = 0; k < 16; k++) begin
         capture({k[1:0], k[3:0]});
      end
      results();
   end
endmodule // pcs_strap_core_tb

`default_nettype wire
